/* sio_core.v */
// Safety IO, interrupt, fail-safe and reset output logic
`timescale 1ns/10ps
`include "sio_map.vh"
module sio_core #(
  parameter [23:0] P_RST_SHORT_CYC = `SIO_RST_SHORT_CYC,
  parameter [23:0] P_RST_MID_CYC   = `SIO_RST_MID_CYC,
  parameter [23:0] P_RST_LONG_CYC  = `SIO_RST_LONG_CYC,
  parameter [23:0] P_INT_LONG_CYC  = `SIO_INT_LONG_CYC,
  parameter [23:0] P_INT_SHORT_CYC = `SIO_INT_SHORT_CYC,
  parameter [15:0] P_WAKE_FILT_CYC = `SIO_WAKE_FILT_CYC
) (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire [5:0]  i_io_pin,
  input  wire        i_low_power_off_state_wake,
  input  wire        i_init_phase,
  input  wire        i_wd_running,
  input  wire        i_cfg_we,
  input  wire        i_cfg_int_en,
  input  wire        i_cfg_int_long,
  input  wire        i_cfg_rst_long,
  input  wire [11:0] i_wake_mode,
  input  wire [2:0]  i_safety_en,
  input  wire [1:0]  i_out_en,
  input  wire [1:0]  i_out_val,
  input  wire        i_int_event,
  input  wire        i_fault_event,
  input  wire        i_reset_event,
  input  wire        i_fs_release,
  output reg  [5:0]  o_io_level,
  output reg  [5:0]  o_wake_flag,
  output reg  [2:0]  o_safety_err,
  output reg  [1:0]  o_gate_drv,
  output reg         o_interrupt_pulse_out_n,
  output reg         o_failsafe_out_n,
  output reg         o_reset_out_oe,
  output reg         o_reset_out_o
);
  reg  [5:0]  sync1_reg;
  reg  [5:0]  sync2_reg;
  wire [5:0]  filt;
  reg  [5:0]  prev_reg;
  reg  [5:0]  wake_hit;
  reg         int_en_reg;
  reg         int_long_reg;
  reg         rst_long_reg;
  reg  [23:0] int_cnt_reg;
  reg  [23:0] rst_cnt_reg;
  reg         boot_reg;
  reg  [2:0]  pair_err;
  reg  [2:0]  pair_err_reg;
  reg         lpwake_reg;
  reg  [2:0]  arm_reg;
  integer     k;

  // Wake decision for one pin and its mode
  function wake_fn;
    input [1:0] mode;
    input       now;
    input       prev;
    begin
      case (mode)
        `SIO_WAKE_RISE:   wake_fn = now & ~prev;
        `SIO_WAKE_FALL:   wake_fn = ~now & prev;
        `SIO_WAKE_CHANGE: wake_fn = now ^ prev;
        default:          wake_fn = 1'b0;
      endcase
    end
  endfunction

  // Pins straight from outside the clock domain
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= i_io_pin;
      sync2_reg <= sync1_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_filt
      sio_filter #(
        .P_FILT_CYC (P_WAKE_FILT_CYC)
      ) u_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_level   (sync2_reg[g]),
        .o_level   (filt[g])
      );
    end
  endgenerate

  always @* begin
    for (k = 0; k < 6; k = k + 1) begin
      wake_hit[k] = wake_fn(i_wake_mode[2*k +: 2], filt[k], prev_reg[k]);
    end
    // Pairs are complementary in normal phase; equal levels signal error
    pair_err[0] = i_safety_en[0] & (sync2_reg[0] == sync2_reg[1]);
    pair_err[2] = i_safety_en[2] & (sync2_reg[4] == sync2_reg[5]);
    // Bi-stable only; ignored outside watchdog running
    pair_err[1] = i_safety_en[1] & i_wd_running &
                  (sync2_reg[2] == sync2_reg[3]);
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg     <= 6'h00;
      o_wake_flag  <= 6'h00;
      arm_reg      <= 3'h0;
      o_io_level   <= 6'h00;
      o_safety_err <= 3'h0;
      pair_err_reg <= 3'h0;
      o_gate_drv   <= 2'h0;
    end else begin
      prev_reg     <= filt;
      // Filters jump to the pin level after reset; that is no wake edge
      if (arm_reg != 3'h4) begin
        arm_reg     <= arm_reg + 3'h1;
        o_wake_flag <= 6'h00;
      end else begin
        o_wake_flag <= wake_hit;
      end
      o_io_level   <= sync2_reg;
      pair_err_reg <= pair_err;
      o_safety_err <= pair_err;
      // Only pins 4 and 5 own a driver
      o_gate_drv   <= i_out_en & i_out_val;
    end
  end

  // Init-only configuration; writes outside init are dropped
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_en_reg   <= 1'b1;
      int_long_reg <= 1'b0;
      rst_long_reg <= 1'b0;
    end else if (i_cfg_we && i_init_phase) begin
      int_en_reg   <= i_cfg_int_en;
      int_long_reg <= i_cfg_int_long;
      rst_long_reg <= i_cfg_rst_long;
    end
  end

  // Interrupt pulse; a new event reloads the count
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_cnt_reg             <= 24'h000000;
      o_interrupt_pulse_out_n <= 1'b1;
    end else if (i_int_event && int_en_reg) begin
      int_cnt_reg <= int_long_reg ? P_INT_LONG_CYC :
                     P_INT_SHORT_CYC;
      o_interrupt_pulse_out_n <= 1'b0;
    end else if (int_cnt_reg > 24'h000001) begin
      int_cnt_reg <= int_cnt_reg - 24'h000001;
    end else begin
      int_cnt_reg             <= 24'h000000;
      o_interrupt_pulse_out_n <= 1'b1;
    end
  end

  // Wake from low power off is an external level, synchronised
  reg lpw1_reg;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lpw1_reg   <= 1'b0;
      lpwake_reg <= 1'b0;
    end else begin
      lpw1_reg   <= i_low_power_off_state_wake;
      lpwake_reg <= lpw1_reg;
    end
  end

  // Fail-safe output: low from reset, released only on request
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_failsafe_out_n <= 1'b0;
    end else if (lpwake_reg) begin
      o_failsafe_out_n <= 1'b0;
    end else if (i_fault_event || (|pair_err_reg)) begin
      // Fault wins over a release in the same cycle
      o_failsafe_out_n <= 1'b0;
    end else if (i_fs_release) begin
      o_failsafe_out_n <= 1'b1;
    end
  end

  // Reset output, open drain: only ever pulls low
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_reg       <= 1'b1;
      rst_cnt_reg    <= 24'h000000;
      o_reset_out_oe <= 1'b1;
      o_reset_out_o  <= 1'b0;
    end else begin
      o_reset_out_o <= 1'b0;
      if (boot_reg || lpwake_reg) begin
        boot_reg       <= 1'b0;
        rst_cnt_reg    <= P_RST_LONG_CYC;
        o_reset_out_oe <= 1'b1;
      end else if (i_reset_event) begin
        rst_cnt_reg <= rst_long_reg ? P_RST_MID_CYC :
                       P_RST_SHORT_CYC;
        o_reset_out_oe <= 1'b1;
      end else if (rst_cnt_reg > 24'h000001) begin
        rst_cnt_reg <= rst_cnt_reg - 24'h000001;
      end else begin
        rst_cnt_reg    <= 24'h000000;
        o_reset_out_oe <= 1'b0;
      end
    end
  end
endmodule

/* sio_map.vh */
// Constants for the safety IO and reset output block
// Behaviour
// - Interrupt output pulses low on any interrupt event while pulses are enabled, else stays high
// - Interrupt mode and pulse length accepted only during init phase
// - Long interrupt pulse lasts at least 90 us, nominal 100 us
// - Short interrupt pulse lasts at least 20 us, nominal 25 us
// - Six pins all read and wake; only pins 4 and 5 can drive
// - Pins 4 and 5 as outputs drive an external low-side switch gate
// - Wake-up on rising edge, falling edge or change from recorded state
// - Wake-up input accepted only after stable for the filter time
// - Synchronised level of every pin is readable as status
// - Pins 0 and 1 as safety inputs monitor one external error pair
// - Pins 4 and 5 as safety inputs monitor one external error pair
// - Pins 2 and 3 monitor controller error pair, bi-stable protocol only
// - Pins 2 and 3 monitored only in watchdog running; non-normal is error
// - Fail-safe output goes low on any qualifying fault
// - Fail-safe output held low after power-on and low-power-off wake
// - Controller release request drives fail-safe output high
// - Reset output active low, open drain, external pull-up
// - Power-on or low-power-off exit uses the longest reset hold
// - Fault resets in normal operation hold 1.0 ms or 10 ms as set
// - Reset duration setting writable only in fail-safe init phase
`ifndef SIO_MAP_VH
`define SIO_MAP_VH
`define SIO_CLK_MHZ        200
`define SIO_INT_LONG_US    100
`define SIO_INT_SHORT_US   25
`define SIO_WAKE_FILT_US   70
`define SIO_RST_SHORT_US   1000
`define SIO_RST_MID_US     10000
`define SIO_RST_LONG_US    20000
// Cycle counts at the 200 MHz clock, sized to the counters
`define SIO_RST_SHORT_CYC  24'h030D40
`define SIO_RST_MID_CYC    24'h1E8480
`define SIO_RST_LONG_CYC   24'h3D0900
`define SIO_INT_LONG_CYC   24'h004E20
`define SIO_INT_SHORT_CYC  24'h001388
`define SIO_WAKE_FILT_CYC  16'h36B0
`define SIO_WAKE_RISE      2'h0
`define SIO_WAKE_FALL      2'h1
`define SIO_WAKE_CHANGE    2'h2
`define SIO_WAKE_OFF       2'h3
`define SIO_CNT_W          24
`endif

/* sio_filter.v */
// Stability filter for one synchronised pin
`timescale 1ns/10ps
module sio_filter #(
  parameter [15:0] P_FILT_CYC = 16'h36B0
) (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_level,
  output reg  o_level
);
  reg [15:0] cnt_reg;
  reg [1:0]  prime_reg;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg   <= 16'h0000;
      prime_reg <= 2'h0;
      o_level   <= 1'b0;
    end else if (prime_reg != 2'h3) begin
      // Follow the pin until the synchroniser has filled after reset
      prime_reg <= prime_reg + 2'h1;
      o_level   <= i_level;
      cnt_reg   <= 16'h0000;
    end else if (i_level == o_level) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg >= P_FILT_CYC - 16'h0001) begin
      // Accept only after the level held for the full window
      o_level <= i_level;
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule

/* sio_chk.sv */
// Port checker for the safety IO block
`timescale 1ns/10ps
module sio_chk #(
  parameter [23:0] P_RST_SHORT_CYC = 24'h14,
  parameter [23:0] P_RST_MID_CYC   = 24'h32,
  parameter [23:0] P_INT_LONG_CYC  = 24'h0A,
  parameter [23:0] P_INT_SHORT_CYC = 24'h05
) (
  input wire       i_sys_clk,
  input wire       i_rst_n,
  input wire [5:0] i_io_pin,
  input wire       i_low_power_off_state_wake,
  input wire       i_init_phase,
  input wire       i_cfg_we,
  input wire       i_cfg_int_long,
  input wire       i_cfg_rst_long,
  input wire       i_int_event,
  input wire       i_fault_event,
  input wire       i_reset_event,
  input wire [5:0] o_io_level,
  input wire       o_interrupt_pulse_out_n,
  input wire       o_failsafe_out_n,
  input wire       o_reset_out_oe,
  input wire       o_reset_out_o
);
  reg        lg_reg;
  reg        rl_reg;
  reg [2:0]  up_reg;
  reg [23:0] ic_reg;
  reg [23:0] ie_reg;
  reg [23:0] rc_reg;
  reg [23:0] re_reg;
  // Zero expectation after wake, so long holds are not judged here
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {lg_reg, rl_reg, up_reg} <= 5'h0;
      {ic_reg, ie_reg, rc_reg, re_reg} <= 96'h0;
    end else begin
      if (i_cfg_we && i_init_phase) begin
        lg_reg <= i_cfg_int_long;
        rl_reg <= i_cfg_rst_long;
      end
      if (up_reg != 3'h7)
        up_reg <= up_reg + 3'h1;
      ic_reg <= i_int_event ? 24'h0 : ic_reg + 24'h1;
      rc_reg <= i_reset_event ? 24'h0 : rc_reg + 24'h1;
      if (i_int_event)
        ie_reg <= lg_reg ? P_INT_LONG_CYC : P_INT_SHORT_CYC;
      if (i_low_power_off_state_wake)
        re_reg <= 24'h0;
      else if (i_reset_event)
        re_reg <= rl_reg ? P_RST_MID_CYC : P_RST_SHORT_CYC;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_int_low; i_int_event |=> !o_interrupt_pulse_out_n; endproperty
  a_int_low: assert property (p_int_low)
    else $error("int pulse missing");
  property p_int_len;
    $rose(o_interrupt_pulse_out_n) |-> ic_reg == ie_reg;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("int pulse length");
  property p_rst_on; i_reset_event |=> o_reset_out_oe; endproperty
  a_rst_on: assert property (p_rst_on)
    else $error("reset not driven");
  property p_rst_len;
    re_reg != 24'h0 && $fell(o_reset_out_oe) |-> rc_reg == re_reg;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset hold length");
  property p_rst_od; o_reset_out_o == 1'b0; endproperty
  a_rst_od: assert property (p_rst_od)
    else $error("reset drives high");
  property p_fs_flt; i_fault_event |=> !o_failsafe_out_n; endproperty
  a_fs_flt: assert property (p_fs_flt)
    else $error("fail-safe not low");
  property p_fs_wk; i_low_power_off_state_wake |-> ##[1:4] !o_failsafe_out_n; endproperty
  a_fs_wk: assert property (p_fs_wk)
    else $error("fail-safe not low on wake");
  property p_io; up_reg == 3'h7 |-> o_io_level == $past(i_io_pin, 3);
  endproperty
  a_io: assert property (p_io)
    else $error("pin level latency");
endmodule

/* sio_mcu.sv */
// Controller model: error pair outputs and release request
`timescale 1ns/10ps
module sio_mcu (
  input  wire       i_sys_clk,
  input  wire       i_ask,
  input  wire       i_bad,
  output reg  [1:0] o_pair,
  output reg        o_release
);
  initial {o_pair, o_release} = 3'h2;
  always @(posedge i_sys_clk) begin
    o_pair <= #1 i_bad ? 2'h3 : 2'h1;
    o_release <= #1 i_ask;
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the safety IO block
`timescale 1ns/10ps
module tb_top;
  localparam [23:0] RS = 24'h14, RM = 24'h32, RL = 24'h64;
  localparam [23:0] IL = 24'h0A, IS = 24'h05;
  localparam [15:0] FI = 16'h10;
  reg         clk, rst_n, wk, ini, wd, we, il, rl, ie, fe, re, ask, bad;
  reg         ien;
  reg  [3:0]  pin;
  reg  [11:0] wm;
  reg  [2:0]  se;
  reg  [1:0]  oen, ov;
  wire [1:0]  pair, gate;
  wire [5:0]  lvl, wf;
  wire [2:0]  err;
  wire        int_n, fs_n, oe, rel;
  integer     error_cnt, check_count, seed, n, k;
  sio_core #(.P_RST_SHORT_CYC(RS), .P_RST_MID_CYC(RM),
    .P_RST_LONG_CYC(RL), .P_INT_LONG_CYC(IL),
    .P_INT_SHORT_CYC(IS), .P_WAKE_FILT_CYC(FI)) i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_low_power_off_state_wake(wk),
    .i_io_pin({pin[3:2], pair, pin[1:0]}), .i_init_phase(ini),
    .i_wd_running(wd), .i_cfg_we(we), .i_cfg_int_en(ien),
    .i_cfg_int_long(il), .i_cfg_rst_long(rl), .i_wake_mode(wm),
    .i_safety_en(se), .i_out_en(oen), .i_out_val(ov), .i_int_event(ie),
    .i_fault_event(fe), .i_reset_event(re), .i_fs_release(rel),
    .o_io_level(lvl), .o_wake_flag(wf), .o_safety_err(err),
    .o_gate_drv(gate), .o_interrupt_pulse_out_n(int_n),
    .o_failsafe_out_n(fs_n), .o_reset_out_oe(oe), .o_reset_out_o());
  sio_mcu i_mcu (.i_sys_clk(clk), .i_ask(ask), .i_bad(bad),
    .o_pair(pair), .o_release(rel));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task cyc(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [8*8:1] nm);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s exp %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // Bounded so a stuck output cannot hang the run
  task span(input integer s);
    begin
      n = 0;
      while ((s == 0 ? !int_n : s == 1 ? oe : !wf[0]) === 1'b1 &&
             n < 400) begin
        cyc(1);
        n = n + 1;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    close_out;
  end
  initial begin
    {seed, error_cnt, check_count} = {32'hcae0, 64'h0};
    {rst_n, wk, ini, wd, we, il, rl, ie, fe, re, ask, bad, ien} = 13'h0;
    {pin, wm, se, oen, ov} = {4'h6, 12'hFFF, 7'h0};
    cyc(2);
    rst_n = 1'b1;
    span(1);
    chk(n >= RL && n <= RL + 2, 1, "rst_por");
    chk(fs_n, 0, "fs_por");
    for (k = 0; k < 2; k = k + 1) begin
      {ini, we, il, rl, ien} = {2'h3, k[0], k[0], 1'b1};
      cyc(1);
      // Late write would switch pulses off and flip both lengths
      {ini, il, rl, ien} = {1'b0, ~k[0], ~k[0], 1'b0};
      cyc(1);
      {we, ie} = 2'h1;
      cyc(1);
      ie = 1'b0;
      span(0);
      chk(n, k ? IL : IS, "int_len");
      re = 1'b1;
      cyc(1);
      re = 1'b0;
      span(1);
      chk(n, k ? RM : RS, "rst_len");
    end
    $display("pulse test done");
    ask = 1'b1;
    cyc(1);
    ask = 1'b0;
    cyc(3);
    chk(fs_n, 1, "fs_free");
    // Release reaches the pins a cycle late, so it meets the fault
    ask = 1'b1;
    cyc(1);
    {ask, fe} = 2'h1;
    cyc(1);
    fe = 1'b0;
    cyc(3);
    chk(fs_n, 0, "fs_fault");
    for (k = 0; k < 8; k = k + 1) begin
      n = $random(seed);
      pin = n[3:0];
      cyc(4);
      chk(lvl, {pin[3:2], 2'h1, pin[1:0]}, "io_lvl");
    end
    {se, pin} = 7'h5F;
    cyc(6);
    chk(err, 3'h5, "pair_eq");
    {se, wd, bad, pin} = 9'h1F6;
    cyc(8);
    chk(err, 3'h2, "pair_mcu");
    wd = 1'b0;
    cyc(8);
    chk(err, 3'h0, "pair_off");
    {se, bad, oen, ov} = 8'h0B;
    cyc(3);
    chk(gate, 2'h2, "gate");
    $display("pin test done");
    for (k = 0; k < 3; k = k + 1) begin
      {wm[1:0], pin[0]} = {k[1:0], k == 1};
      cyc(FI + 8);
      pin[0] = k != 1;
      span(2);
      chk(n >= FI && n <= FI + 6, 1, "wake");
    end
    ask = 1'b1;
    cyc(1);
    {ask, wk} = 2'h1;
    cyc(1);
    wk = 1'b0;
    cyc(5);
    chk(fs_n, 0, "fs_wake");
    span(1);
    chk(n > RL - 8 && n <= RL, 1, "rst_wake");
    $display("wake test done");
    close_out;
  end
endmodule
bind sio_core sio_chk #(.P_RST_SHORT_CYC(P_RST_SHORT_CYC),
  .P_RST_MID_CYC(P_RST_MID_CYC), .P_INT_LONG_CYC(P_INT_LONG_CYC),
  .P_INT_SHORT_CYC(P_INT_SHORT_CYC)) u_chk (.i_sys_clk, .i_rst_n,
  .i_io_pin, .i_low_power_off_state_wake, .i_init_phase, .i_cfg_we, .i_cfg_int_long,
  .i_cfg_rst_long, .i_int_event, .i_fault_event, .i_reset_event,
  .o_io_level, .o_interrupt_pulse_out_n, .o_failsafe_out_n,
  .o_reset_out_oe, .o_reset_out_o);
